// file: rtl/alee_core.sv
/*
 * Analog input limit and delta event detection with its object dictionary
 * entries, plus the emergency telegram assembler.
 * Assumes the field-bus stack presents one object access, one sample or one
 * transmitted-value notice at a time under a valid/ready handshake, all
 * synchronous to clk_i.
 */
//
// Overview of operation
// - Value above upper limit raises event
// - Upper limit per channel, signed, default FFFFH
// - Value below lower limit raises event
// - Lower limit per channel, signed, default zero
// - Change from last sent reaching delta
// - Delta per channel, unsigned, default FFFFH
// - Sub-entry zero of the per-channel objects reports channel count, read-only
// - Emergency telegram payload is eight bytes
// - Error code in bytes one and zero
// - Error register copy in byte two
// - Affected module number in byte three
// - Status word in bytes seven to four
// - Trigger bits enable upper, lower, delta
// - Source words mark channels, clear on read
// - Global enable gates all events
`timescale 1ns/1ps
module alee_core (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  chan_count_i,
    input  wire logic        od_req_i,
    input  wire logic        od_we_i,
    input  wire logic [15:0] od_index_i,
    input  wire logic [7:0]  od_subidx_i,
    input  wire logic [31:0] od_wdata_i,
    output logic             od_ready_o,
    output logic             od_ack_o,
    output logic             od_abort_o,
    output logic [31:0]      od_rdata_o,
    input  wire logic        samp_valid_i,
    input  wire logic [6:0]  samp_ch_i,
    input  wire logic [31:0] samp_val_i,
    output logic             samp_ready_o,
    input  wire logic        xmit_valid_i,
    input  wire logic [6:0]  xmit_ch_i,
    input  wire logic [31:0] xmit_val_i,
    output logic             xmit_ready_o,
    output logic             event_o,
    output logic [6:0]       event_ch_o,
    input  wire logic        emcy_req_i,
    input  wire logic [15:0] emcy_code_i,
    input  wire logic [7:0]  emcy_errreg_i,
    input  wire logic [7:0]  emcy_module_i,
    input  wire logic [31:0] emcy_status_i,
    output logic             emcy_req_ready_o,
    output logic             emcy_valid_o,
    output logic [63:0]      emcy_data_o,
    input  wire logic        emcy_ready_i
);

    // -------------------------------------------------------------------
    // State and latched request
    // -------------------------------------------------------------------
    alee_pkg::alee_state_t state_r, state_nxt;
    logic                  we_r;
    logic [15:0]           idx_r;
    logic [7:0]            sub_r;
    logic [31:0]           wdata_r;
    logic [6:0]            ch_r;
    logic [31:0]           val_r;
    logic                  gen_r;
    logic [31:0]           src_r [alee_pkg::GROUPS];
    logic [31:0]           upper_q, lower_q, delta_q, last_q;
    logic [7:0]            trig_q;

    // Handshakes: object access first, then samples, then notices
    logic idle, take_od, take_samp, take_xmit;
    assign idle         = (state_r == alee_pkg::ST_IDLE);
    assign od_ready_o   = idle;
    assign samp_ready_o = idle && !od_req_i;
    assign xmit_ready_o = idle && !od_req_i && !samp_valid_i;
    assign take_od      = od_req_i && od_ready_o;
    assign take_samp    = samp_valid_i && samp_ready_o;
    assign take_xmit    = xmit_valid_i && xmit_ready_o;

    // -------------------------------------------------------------------
    // Channel count and object decode
    // -------------------------------------------------------------------
    logic [7:0] count_eff;
    logic [8:0] groups_w;
    logic [7:0] groups;
    logic [7:0] sub_m1;
    logic [6:0] od_ch;
    logic       is_arr, is_src, is_gen, sub0, ch_ok, grp_ok;
    logic [1:0] grp;

    // Counts above the table size are clipped so no channel past it is accepted or raises an event
    assign count_eff = (chan_count_i > alee_pkg::MAX_CH) ? alee_pkg::MAX_CH : chan_count_i;
    assign groups_w  = ({1'b0, count_eff} + 9'h01F) >> 5;
    assign groups    = groups_w[7:0];
    assign sub_m1    = sub_r - alee_pkg::SUB_FIRST;
    assign od_ch     = sub_m1[6:0];
    assign grp       = sub_m1[1:0];
    assign is_arr    = (idx_r == alee_pkg::IDX_UPPER) || (idx_r == alee_pkg::IDX_LOWER)
                    || (idx_r == alee_pkg::IDX_DELTA) || (idx_r == alee_pkg::IDX_TRIG);
    assign is_src    = (idx_r == alee_pkg::IDX_SRC);
    assign is_gen    = (idx_r == alee_pkg::IDX_GEN);
    assign sub0      = (sub_r == alee_pkg::SUB_COUNT);
    assign ch_ok     = !sub0 && (sub_m1 < count_eff);
    assign grp_ok    = !sub0 && (sub_m1 < groups);

    // Access outcome in the object stage; sub-entry zero is read-only except in the global enable object
    logic in_od, od_ok, wr_arr, wr_gen, rd_src;
    assign in_od  = (state_r == alee_pkg::ST_OD);
    assign wr_arr = in_od && we_r && is_arr && ch_ok;
    assign wr_gen = in_od && we_r && is_gen && sub0;
    assign rd_src = in_od && !we_r && is_src && grp_ok;
    assign od_ok  = we_r ? ((is_arr && ch_ok) || (is_gen && sub0))
                         : ((is_arr && (sub0 || ch_ok)) || (is_src && (sub0 || grp_ok))
                            || (is_gen && sub0));

    // Read data selection
    logic [31:0] arr_q, rd_val;
    assign arr_q  = (idx_r == alee_pkg::IDX_UPPER) ? upper_q
                  : (idx_r == alee_pkg::IDX_LOWER) ? lower_q
                  : (idx_r == alee_pkg::IDX_DELTA) ? delta_q
                  : {24'h000000, trig_q};
    assign rd_val = (is_arr && sub0) ? {24'h000000, count_eff}
                  : is_arr           ? arr_q
                  : (is_src && sub0) ? {24'h000000, groups}
                  : is_src           ? src_r[grp]
                  : {31'h00000000, gen_r};

    // -------------------------------------------------------------------
    // Per-channel tables
    // -------------------------------------------------------------------
    logic [6:0] raddr;
    logic [7:0] in_m1;
    // A plain net, not a function, so the address follows every sub-index change
    assign in_m1 = od_subidx_i - alee_pkg::SUB_FIRST;
    assign raddr = !idle ? (in_od ? od_ch : ch_r)
                 : (od_req_i ? in_m1[6:0] : samp_ch_i);

    logic we_up, we_lo, we_de, we_tr;
    assign we_up = wr_arr && (idx_r == alee_pkg::IDX_UPPER);
    assign we_lo = wr_arr && (idx_r == alee_pkg::IDX_LOWER);
    assign we_de = wr_arr && (idx_r == alee_pkg::IDX_DELTA);
    assign we_tr = wr_arr && (idx_r == alee_pkg::IDX_TRIG);

    alee_mem #(.WIDTH(32), .RESET_VAL(alee_pkg::UPPER_RST)) u_upper (
        .clk_i(clk_i), .reset_i(reset_i), .we_i(we_up), .waddr_i(od_ch),
        .wdata_i(wdata_r), .raddr_i(raddr), .rdata_o(upper_q));
    alee_mem #(.WIDTH(32), .RESET_VAL(alee_pkg::LOWER_RST)) u_lower (
        .clk_i(clk_i), .reset_i(reset_i), .we_i(we_lo), .waddr_i(od_ch),
        .wdata_i(wdata_r), .raddr_i(raddr), .rdata_o(lower_q));
    alee_mem #(.WIDTH(32), .RESET_VAL(alee_pkg::DELTA_RST)) u_delta (
        .clk_i(clk_i), .reset_i(reset_i), .we_i(we_de), .waddr_i(od_ch),
        .wdata_i(wdata_r), .raddr_i(raddr), .rdata_o(delta_q));
    alee_mem #(.WIDTH(8), .RESET_VAL(alee_pkg::TRIG_RST)) u_trig (
        .clk_i(clk_i), .reset_i(reset_i), .we_i(we_tr), .waddr_i(od_ch),
        .wdata_i(wdata_r[7:0]), .raddr_i(raddr), .rdata_o(trig_q));
    // Last transmitted value; a notice writes it while nothing else runs
    alee_mem #(.WIDTH(32), .RESET_VAL(alee_pkg::LAST_RST)) u_last (
        .clk_i(clk_i), .reset_i(reset_i), .we_i(take_xmit), .waddr_i(xmit_ch_i),
        .wdata_i(xmit_val_i), .raddr_i(raddr), .rdata_o(last_q));

    // -------------------------------------------------------------------
    // Event evaluation
    // -------------------------------------------------------------------
    logic        upper_hit, lower_hit, delta_hit, samp_ok, fire;
    logic [32:0] diff;
    logic [31:0] mag;
    assign upper_hit = $signed(val_r) > $signed(upper_q);
    assign lower_hit = $signed(val_r) < $signed(lower_q);
    assign diff      = {val_r[31], val_r} - {last_q[31], last_q};
    // Magnitude fits 32 bits unsigned since both operands are 32-bit signed
    assign mag       = diff[32] ? 32'(-diff) : diff[31:0];
    assign delta_hit = mag >= delta_q;
    assign samp_ok   = (state_r == alee_pkg::ST_CHK) && ({1'b0, ch_r} < count_eff);
    assign fire      = samp_ok && gen_r
                    && ((trig_q[alee_pkg::TRIG_UPPER_BIT] && upper_hit)
                     || (trig_q[alee_pkg::TRIG_LOWER_BIT] && lower_hit)
                     || (trig_q[alee_pkg::TRIG_DELTA_BIT] && delta_hit));

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            alee_pkg::ST_IDLE: begin
                if (take_od) begin
                    state_nxt = alee_pkg::ST_OD;
                end else if (take_samp) begin
                    state_nxt = alee_pkg::ST_CHK;
                end
            end
            alee_pkg::ST_OD:  state_nxt = alee_pkg::ST_IDLE;
            alee_pkg::ST_CHK: state_nxt = alee_pkg::ST_IDLE;
            default:          state_nxt = alee_pkg::ST_IDLE;
        endcase
    end

    // Sequencer and latched request fields
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= alee_pkg::ST_IDLE;
            {we_r, idx_r, sub_r, wdata_r, ch_r, val_r} <= '0;
        end else begin
            state_r <= state_nxt;
            if (take_od) begin
                {we_r, idx_r, sub_r, wdata_r} <= {od_we_i, od_index_i, od_subidx_i, od_wdata_i};
            end
            if (take_samp) begin
                {ch_r, val_r} <= {samp_ch_i, samp_val_i};
            end
        end
    end

    // Answers and events, one-cycle pulses with registered data
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            {od_ack_o, od_abort_o, od_rdata_o, event_o, event_ch_o} <= '0;
            gen_r <= alee_pkg::GEN_RST;
        end else begin
            od_ack_o   <= in_od && od_ok;
            od_abort_o <= in_od && !od_ok;
            if (in_od && od_ok && !we_r) begin
                od_rdata_o <= rd_val;
            end
            if (wr_gen) begin
                gen_r <= wdata_r[0];
            end
            event_o <= fire;
            if (fire) begin
                event_ch_o <= ch_r;
            end
        end
    end

    // -------------------------------------------------------------------
    // Interrupt source words
    // -------------------------------------------------------------------
    // A set arriving with the clearing read survives the clear
    genvar g;
    generate
        for (g = 0; g < alee_pkg::GROUPS; g++) begin : g_src
            logic [31:0] set_m;
            logic        clr;
            assign set_m = (fire && ch_r[6:5] == 2'(g)) ? (32'h00000001 << ch_r[4:0]) : '0;
            assign clr   = rd_src && (grp == 2'(g));
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    src_r[g] <= '0;
                end else begin
                    src_r[g] <= (clr ? 32'h00000000 : src_r[g]) | set_m;
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // Emergency telegram
    // -------------------------------------------------------------------
    alee_emcy u_emcy (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .req_i       (emcy_req_i),
        .code_i      (emcy_code_i),
        .errreg_i    (emcy_errreg_i),
        .module_i    (emcy_module_i),
        .status_i    (emcy_status_i),
        .req_ready_o (emcy_req_ready_o),
        .valid_o     (emcy_valid_o),
        .data_o      (emcy_data_o),
        .ready_i     (emcy_ready_i)
    );

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_upper_event: assert property (samp_ok && gen_r && trig_q[0] && upper_hit
        |=> event_o && event_ch_o == $past(ch_r))
        else $error("upper limit crossing missed");
    a_lower_event: assert property (samp_ok && gen_r && trig_q[1] && lower_hit |=> event_o)
        else $error("lower limit crossing missed");
    a_delta_event: assert property (samp_ok && gen_r && trig_q[2] && delta_hit |=> event_o)
        else $error("delta event missed");
    a_global_gate: assert property (!gen_r |=> !event_o)
        else $error("event raised while globally disabled");
    a_trig_gate: assert property (samp_ok && trig_q[2:0] == 3'b000 |=> !event_o)
        else $error("event raised with no trigger selected");
    a_count_read: assert property (in_od && !we_r && is_arr && sub0
        |=> od_ack_o && od_rdata_o == {24'h000000, $past(count_eff)})
        else $error("channel count read wrong");
    a_count_ro: assert property (in_od && we_r && is_arr && sub0 |=> od_abort_o && !od_ack_o)
        else $error("write to channel count accepted");
    a_src_set: assert property (fire |=> src_r[$past(ch_r[6:5])][$past(ch_r[4:0])])
        else $error("source bit not set by event");
    a_src_clear: assert property (rd_src && !fire |=> src_r[$past(grp)] == 32'h00000000)
        else $error("source word not cleared by read");
    a_upper_store: assert property (we_up |=> u_upper.mem_r[$past(od_ch)] == $past(wdata_r))
        else $error("upper limit write lost");
    a_answer_once: assert property (take_od |=> in_od ##1 (od_ack_o ^ od_abort_o))
        else $error("object access not answered in two cycles");

    c_upper_event: cover property (samp_ok && upper_hit && fire);
    c_delta_event: cover property (samp_ok && delta_hit && fire);
    c_src_readclr: cover property (rd_src && src_r[grp] != 32'h00000000);
    c_emcy_sent:   cover property (emcy_valid_o && emcy_ready_i);

endmodule : alee_core

// file: rtl/alee_pkg.sv
/*
 * Constants, object indices and state codes shared by the analog limit
 * event and emergency telegram design files.
 * Assumes a single 50 MHz clock domain and a synchronous active-high reset.
 */
package alee_pkg;

    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int          NUM_CH    = 112;
    localparam int          CH_W      = 7;
    localparam int          GROUPS    = 4;
    localparam int          GROUP_W   = 32;
    localparam logic [7:0]  MAX_CH    = 8'h70;

    // -------------------------------------------------------------------
    // Object dictionary indices and sub-indices
    // -------------------------------------------------------------------
    localparam logic [15:0] IDX_TRIG  = 16'h6421;
    localparam logic [15:0] IDX_SRC   = 16'h6422;
    localparam logic [15:0] IDX_GEN   = 16'h6423;
    localparam logic [15:0] IDX_UPPER = 16'h6424;
    localparam logic [15:0] IDX_LOWER = 16'h6425;
    localparam logic [15:0] IDX_DELTA = 16'h6426;
    localparam logic [7:0]  SUB_COUNT = 8'h00;
    localparam logic [7:0]  SUB_FIRST = 8'h01;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [31:0] UPPER_RST = 32'h0000FFFF;
    localparam logic [31:0] LOWER_RST = 32'h00000000;
    localparam logic [31:0] DELTA_RST = 32'h0000FFFF;
    localparam logic [31:0] LAST_RST  = 32'h00000000;
    localparam logic [7:0]  TRIG_RST  = 8'h00;
    localparam logic        GEN_RST   = 1'b1;

    // -------------------------------------------------------------------
    // Trigger selection bits
    // -------------------------------------------------------------------
    localparam int          TRIG_UPPER_BIT = 0;
    localparam int          TRIG_LOWER_BIT = 1;
    localparam int          TRIG_DELTA_BIT = 2;

    // -------------------------------------------------------------------
    // Emergency payload field positions (bit offsets, LSB first)
    // -------------------------------------------------------------------
    localparam int          EMCY_CODE_LSB   = 0;
    localparam int          EMCY_ERRREG_LSB = 16;
    localparam int          EMCY_MODULE_LSB = 24;
    localparam int          EMCY_STATUS_LSB = 32;
    localparam int          EMCY_BYTES      = 8;

    // -------------------------------------------------------------------
    // Controller states
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OD   = 2'b01,
        ST_CHK  = 2'b10
    } alee_state_t;

endpackage : alee_pkg

// file: rtl/alee_mem.sv
/*
 * Small per-channel table with one write port and a registered read port.
 * Entries never written read back as the reset value, so a reset restores
 * every default without sweeping the array. Assumes in-range addresses.
 */
`timescale 1ns/1ps
module alee_mem #(
    parameter int               WIDTH     = 32,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic                     clk_i,
    input  wire logic                     reset_i,
    input  wire logic                     we_i,
    input  wire logic [alee_pkg::CH_W-1:0] waddr_i,
    input  wire logic [WIDTH-1:0]         wdata_i,
    input  wire logic [alee_pkg::CH_W-1:0] raddr_i,
    output logic      [WIDTH-1:0]         rdata_o
);

    logic [WIDTH-1:0]            mem_r [alee_pkg::NUM_CH];
    logic [alee_pkg::NUM_CH-1:0] written_r;

    // Storage has no reset; the written flags stand in for it
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // Written flags and registered read data
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            written_r <= '0;
            rdata_o   <= RESET_VAL;
        end else begin
            if (we_i) begin
                written_r[waddr_i] <= 1'b1;
            end
            rdata_o <= written_r[raddr_i] ? mem_r[raddr_i] : RESET_VAL;
        end
    end

endmodule : alee_mem

// file: rtl/alee_emcy.sv
/*
 * Emergency telegram assembler: packs code, error register copy, module
 * number and status word into an eight-byte payload and holds it until
 * the transmitter takes it. Assumes the transmitter raises ready for one
 * cycle when it has taken the payload.
 */
`timescale 1ns/1ps
module alee_emcy (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        req_i,
    input  wire logic [15:0] code_i,
    input  wire logic [7:0]  errreg_i,
    input  wire logic [7:0]  module_i,
    input  wire logic [31:0] status_i,
    output logic             req_ready_o,
    output logic             valid_o,
    output logic [63:0]      data_o,
    input  wire logic        ready_i
);

    logic [63:0] payload;
    logic        take;

    // Little-endian packing, every field low byte first
    assign payload[alee_pkg::EMCY_CODE_LSB   +: 16] = code_i;
    assign payload[alee_pkg::EMCY_ERRREG_LSB +: 8]  = errreg_i;
    assign payload[alee_pkg::EMCY_MODULE_LSB +: 8]  = module_i;
    assign payload[alee_pkg::EMCY_STATUS_LSB +: 32] = status_i;
    assign req_ready_o = !valid_o;
    assign take        = req_i && !valid_o;

    // Payload stands unchanged until handed over
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            valid_o <= 1'b0;
            data_o  <= '0;
        end else if (take) begin
            valid_o <= 1'b1;
            data_o  <= payload;
        end else if (ready_i) begin
            valid_o <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_emcy_fields: assert property (@(posedge clk_i) disable iff (reset_i)
        take |=> data_o[15:0] == $past(code_i) && data_o[23:16] == $past(errreg_i)
                 && data_o[31:24] == $past(module_i) && data_o[63:32] == $past(status_i))
        else $error("emergency payload fields misplaced");
    a_emcy_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        valid_o && !ready_i |=> valid_o && $stable(data_o))
        else $error("emergency payload changed before hand-over");

endmodule : alee_emcy

// file: tb/alee_master.sv
/* Object bus master model, one access at a time.
   Assumes the bench samples od_rdata_o itself when access returns. */
`timescale 1ns/1ps
module alee_master (
    input  wire logic   clk_i,
    input  wire logic   od_ready_i,
    input  wire logic   od_ack_i,
    input  wire logic   od_abort_i,
    output logic        od_req_o,
    output logic        od_we_o,
    output logic [15:0] od_index_o,
    output logic [7:0]  od_subidx_o,
    output logic [31:0] od_wdata_o
);
    initial {od_req_o, od_we_o, od_index_o, od_subidx_o, od_wdata_o} = '0;
    // Held until the taking edge; released index, sub-index and data lines are inverted, od_we_o is left as it was
    task automatic access(input logic we, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wd, output logic ok);
        @(posedge clk_i);
        #1;
        {od_req_o, od_we_o, od_index_o, od_subidx_o, od_wdata_o} = {1'b1, we, idx, sub, wd};
        while (!od_ready_i) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        #1;
        {od_req_o, od_index_o, od_subidx_o, od_wdata_o} = {1'b0, ~idx, ~sub, ~wd};
        @(posedge clk_i);
        #1;
        ok = od_ack_i ? 1'b1 : (od_abort_i ? 1'b0 : 1'bx);
    endtask : access
endmodule : alee_master

// file: tb/alee_core_bench.sv
/* Self-checking bench for alee_core against an integer model.
   Assumes the 50 MHz clock and synchronous reset of the design. */
`timescale 1ns/1ps
module alee_core_bench;
    logic clk_i, reset_i, od_req_i, od_we_i, od_ready_o, od_ack_o, od_abort_o, samp_valid_i;
    logic samp_ready_o, xmit_valid_i, xmit_ready_o, event_o, emcy_req_i, emcy_req_ready_o;
    logic emcy_valid_o, emcy_ready_i;
    logic [6:0] samp_ch_i, xmit_ch_i, event_ch_o;
    logic [7:0] chan_count_i, od_subidx_i, emcy_errreg_i, emcy_module_i;
    logic [15:0] od_index_i, emcy_code_i;
    logic [31:0] od_wdata_i, od_rdata_o, samp_val_i, xmit_val_i, emcy_status_i;
    logic [63:0] emcy_data_o;
    int up[5], lo[5], dl[5], tr[5], last[5];
    int en, src, fail_count, checks;
    alee_core i_dut (.clk_i, .reset_i, .chan_count_i, .od_req_i, .od_we_i, .od_index_i,
        .od_subidx_i, .od_wdata_i, .od_ready_o, .od_ack_o, .od_abort_o, .od_rdata_o,
        .samp_valid_i, .samp_ch_i, .samp_val_i, .samp_ready_o, .xmit_valid_i, .xmit_ch_i,
        .xmit_val_i, .xmit_ready_o, .event_o, .event_ch_o, .emcy_req_i, .emcy_code_i,
        .emcy_errreg_i, .emcy_module_i, .emcy_status_i, .emcy_req_ready_o, .emcy_valid_o,
        .emcy_data_o, .emcy_ready_i);
    alee_master i_master (.clk_i, .od_ready_i(od_ready_o), .od_ack_i(od_ack_o),
        .od_abort_i(od_abort_o), .od_req_o(od_req_i), .od_we_o(od_we_i),
        .od_index_o(od_index_i), .od_subidx_o(od_subidx_i), .od_wdata_o(od_wdata_i));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------------
    // Model and bus tasks
    // ------------------------------------------------------------------
    function automatic int exp_ev(int ch, int v);
        longint d;
        d = longint'(v) - longint'(last[ch]);
        d = d < 0 ? -d : d;
        return en & int'((tr[ch][0] && v > up[ch]) || (tr[ch][1] && v < lo[ch])
                         || (tr[ch][2] && d >= longint'(dl[ch])));
    endfunction : exp_ev
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic we, input logic [15:0] idx, input int sub, input int v,
                       input logic [32:0] exp);
        logic ok;
        i_master.access(we, idx, 8'(sub), 32'(v), ok);
        chk({ok, we ? 32'h0 : od_rdata_o}, exp);
    endtask : acc
    // Samples and notices share one driver; the flag picks the port
    task automatic put(input logic is_samp, input int ch, input int v);
        int e;
        e = exp_ev(ch, v);
        @(posedge clk_i);
        #1;
        {samp_valid_i, xmit_valid_i} = {is_samp, !is_samp};
        {samp_ch_i, xmit_ch_i, samp_val_i, xmit_val_i} = {7'(ch), 7'(ch), 32'(v), 32'(v)};
        while (!(is_samp ? samp_ready_o : xmit_ready_o)) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        #1;
        {samp_valid_i, xmit_valid_i, samp_val_i, xmit_val_i} = {2'b0, ~32'(v), ~32'(v)};
        if (is_samp) begin
            @(posedge clk_i);
            #1;
            chk({event_o, e ? event_ch_o : 7'h0}, {1'(e), e ? 7'(ch) : 7'h0});
            src |= e << ch;
        end else last[ch] = v;
    endtask : put
    task automatic test_done;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------------
    // Main sequence; watchdog allows far more than the run needs
    // ------------------------------------------------------------------
    initial begin
        #200000;
        fail_count++;
        test_done;
    end
    initial begin
        {reset_i, chan_count_i, samp_valid_i, xmit_valid_i, emcy_req_i, emcy_ready_i} = 13'h1050;
        {samp_ch_i, xmit_ch_i, samp_val_i, xmit_val_i} = '0;
        {emcy_code_i, emcy_errreg_i, emcy_module_i, emcy_status_i} = '0;
        void'($urandom(32'h9289));
        repeat (16) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        en = 1;
        acc(0, 16'h6424, 1, 0, 33'h10000FFFF);
        acc(0, 16'h6425, 1, 0, 33'h100000000);
        acc(0, 16'h6426, 1, 0, 33'h10000FFFF);
        acc(0, 16'h6426, 0, 0, 33'h100000005);
        acc(1, 16'h6424, 0, 9, 33'h0);
        for (int c = 0; c < 5; c++) begin
            {tr[c], up[c], dl[c]} = {c + 1, int'($urandom_range(500)), int'($urandom_range(300, 50))};
            lo[c] = -up[c];
            acc(1, 16'h6421, c + 1, tr[c], 33'h100000000);
            acc(1, 16'h6424, c + 1, up[c], 33'h100000000);
            acc(1, 16'h6425, c + 1, lo[c], 33'h100000000);
            acc(1, 16'h6426, c + 1, dl[c], 33'h100000000);
        end
        repeat (60) put($urandom_range(1), $urandom_range(4), $urandom_range(2000) - 1000);
        acc(0, 16'h6422, 1, 0, {1'b1, 32'(src)});
        acc(0, 16'h6422, 1, 0, 33'h100000000);
        acc(1, 16'h6423, 0, 0, 33'h100000000);
        en = 0;
        repeat (8) put(1'b1, $urandom_range(4), $urandom_range(2000) - 1000);
        repeat (4) begin
            @(posedge clk_i);
            #1;
            {emcy_code_i, emcy_errreg_i, emcy_module_i, emcy_status_i} = {$urandom, $urandom};
            emcy_req_i = 1'b1;
            @(posedge clk_i);
            #1;
            emcy_req_i = 1'b0;
            chk({emcy_valid_o, emcy_data_o}, {1'b1, emcy_status_i, emcy_module_i,
                emcy_errreg_i, emcy_code_i});
            emcy_ready_i = 1'b1;
            @(posedge clk_i);
            #1;
            emcy_ready_i = 1'b0;
            chk({emcy_valid_o, emcy_req_ready_o}, 2'b01);
        end
        // Mid-run reset must bring back the table and enable defaults
        reset_i = 1'b1;
        @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        acc(0, 16'h6424, 1, 0, 33'h10000FFFF);
        acc(0, 16'h6423, 0, 0, 33'h100000001);
        test_done;
    end
endmodule : alee_core_bench
